// [hw/valve_fieldbus_io_mapping.v]
// Cyclic input/output mapping and bus error configuration for the valve unit
// Functional notes
// - Sensors one to four go in input bits 0-3; bits 4-7 read zero.
// - Only one cyclic input layout exists; nothing selects another.
// - Output bits 0,1,2 drive main, upper and lower pilots; rest ignored.
// - On bus error, behaviour bit 0 low goes safe, high holds; others zero.
// - Safety pattern 0 all off, 1/2/3 turn on one pilot only.
// - Never more than one pilot on while in the safety position.
// - Configuration bytes are read by get and written by set services.
`timescale 1ns/1ps
`include "valve_io_map.vh"
module valve_fieldbus_io_mapping (
    clk,
    rst_b,
    sensor_one,
    sensor_two,
    sensor_three,
    sensor_four,
    in_sample,
    sensor_input_byte,
    out_valid,
    pilot_output_byte_in,
    bus_error,
    attr_get,
    attr_set,
    attr_sel,
    attr_wdata,
    attr_rdata,
    attr_done,
    attr_reject,
    main_stroke_pilot,
    upper_lift_pilot,
    lower_lift_pilot,
    in_safety
);
    // Clock and asynchronous active-low reset
    input wire clk;
    input wire rst_b;
    // Taught sensor levels, high means on
    input wire sensor_one;
    input wire sensor_two;
    input wire sensor_three;
    input wire sensor_four;
    input wire in_sample;
    output reg [7:0] sensor_input_byte;
    // Cyclic output byte and bus state from the master
    input wire out_valid;
    input wire [7:0] pilot_output_byte_in;
    input wire bus_error;
    // Acyclic configuration access
    input wire attr_get;
    input wire attr_set;
    input wire attr_sel;
    input wire [7:0] attr_wdata;
    output reg [7:0] attr_rdata;
    output reg attr_done;
    output reg attr_reject;
    // Pilot drives and safety indication
    output reg main_stroke_pilot;
    output reg upper_lift_pilot;
    output reg lower_lift_pilot;
    output reg in_safety;

    // Configuration bytes and latest cyclic command
    reg [7:0] behaviour_q;
    reg [7:0] behaviour_d;
    reg [7:0] pattern_q;
    reg [7:0] pattern_d;
    reg [2:0] cyclic_q;
    reg [2:0] cyclic_d;
    // Next values of the registered outputs
    reg [7:0] sensor_d;
    reg [2:0] pilot_d;
    reg safety_d;
    reg [7:0] rdata_d;
    reg done_d;
    reg reject_d;
    // Decoded safe pattern and bus error mode
    wire [2:0] safe_pilots;
    wire hold_last;
    wire safety_now;

    // Selector decode, shared by the set and get paths
    function is_behaviour_sel;
        input sel;
        begin
            is_behaviour_sel = (sel == `ATTR_BUS_ERROR_BEHAVIOUR);
        end
    endfunction

    // Only codes up to PATTERN_MAX (all off or one pilot) may be stored
    function pattern_legal;
        input [7:0] value;
        begin
            pattern_legal = (value <= `PATTERN_MAX);
        end
    endfunction

    // Decoder sits on the stored pattern, so it is ready before any bus error
    pilot_safety_decode u_decode (
        .pattern(pattern_q),
        .pilots(safe_pilots)
    );

    // Behaviour bit 0 chooses between hold and safe on bus error
    assign hold_last = behaviour_q[`BEHAVIOUR_HOLD_BIT];
    assign safety_now = bus_error && !hold_last;

    // Sensor capture; one fixed layout, no selector exists
    always @* begin
        sensor_d = sensor_input_byte;
        if (in_sample) begin
            // Upper nibble never carries a valve state
            sensor_d = `INPUT_RESET;
            sensor_d[`SENSOR_ONE_BIT] = sensor_one;
            sensor_d[`SENSOR_TWO_BIT] = sensor_two;
            sensor_d[`SENSOR_THREE_BIT] = sensor_three;
            sensor_d[`SENSOR_FOUR_BIT] = sensor_four;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sensor_input_byte <= `INPUT_RESET;
        end else begin
            sensor_input_byte <= sensor_d;
        end
    end

    // Cyclic command; frozen during bus error so hold mode keeps the last one
    always @* begin
        cyclic_d = cyclic_q;
        if (out_valid && !bus_error) begin
            // Bits 3 to 7 of the byte are left unread on purpose
            cyclic_d[`PILOT_MAIN_BIT] = pilot_output_byte_in[`PILOT_MAIN_BIT];
            cyclic_d[`PILOT_UPPER_BIT] = pilot_output_byte_in[`PILOT_UPPER_BIT];
            cyclic_d[`PILOT_LOWER_BIT] = pilot_output_byte_in[`PILOT_LOWER_BIT];
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cyclic_q <= `PILOT_RESET;
        end else begin
            cyclic_q <= cyclic_d;
        end
    end

    // Pilot source: cyclic normally, safe pattern or held value on bus error
    always @* begin
        pilot_d = cyclic_q;
        safety_d = 1'b0;
        if (safety_now) begin
            pilot_d = safe_pilots;
            safety_d = 1'b1;
        end
    end

    // Pilots registered so a bus error never glitches the valve drives
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            main_stroke_pilot <= 1'b0;
            upper_lift_pilot <= 1'b0;
            lower_lift_pilot <= 1'b0;
            in_safety <= 1'b0;
        end else begin
            main_stroke_pilot <= pilot_d[`PILOT_MAIN_BIT];
            upper_lift_pilot <= pilot_d[`PILOT_UPPER_BIT];
            lower_lift_pilot <= pilot_d[`PILOT_LOWER_BIT];
            in_safety <= safety_d;
        end
    end

    // Acyclic get/set; set wins over a get in the same cycle
    always @* begin
        behaviour_d = behaviour_q;
        pattern_d = pattern_q;
        rdata_d = attr_rdata;
        done_d = attr_get | attr_set;
        reject_d = 1'b0;
        if (attr_set) begin
            if (is_behaviour_sel(attr_sel)) begin
                behaviour_d = attr_wdata & `BEHAVIOUR_MASK;
            end else if (pattern_legal(attr_wdata)) begin
                pattern_d = attr_wdata;
            end else begin
                // Refused code leaves the stored pattern untouched
                reject_d = 1'b1;
            end
        end else if (attr_get) begin
            if (is_behaviour_sel(attr_sel)) begin
                rdata_d = behaviour_q;
            end else begin
                rdata_d = pattern_q;
            end
        end
    end

    // Configuration bytes; reset means safe mode with all pilots off
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            behaviour_q <= `BEHAVIOUR_RESET;
            pattern_q <= `PATTERN_RESET;
        end else begin
            behaviour_q <= behaviour_d;
            pattern_q <= pattern_d;
        end
    end

    // Acyclic answer; done and reject last one cycle, read data until next get
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            attr_rdata <= `RDATA_RESET;
            attr_done <= 1'b0;
            attr_reject <= 1'b0;
        end else begin
            attr_rdata <= rdata_d;
            attr_done <= done_d;
            attr_reject <= reject_d;
        end
    end
endmodule

// [hw/valve_io_map.vh]
// Constants for the valve fieldbus process data mapping
`ifndef VALVE_IO_MAP_VH
`define VALVE_IO_MAP_VH
// Attribute selectors on the acyclic configuration port
`define ATTR_BUS_ERROR_BEHAVIOUR 1'h0
`define ATTR_BUS_ERROR_PILOT_PATTERN 1'h1
// Bus error behaviour field
`define BEHAVIOUR_HOLD_BIT 0
`define BEHAVIOUR_RESET 8'h00
`define BEHAVIOUR_MASK 8'h01
// Pilot pattern codes
`define PATTERN_ALL_OFF 8'h00
`define PATTERN_MAIN 8'h01
`define PATTERN_UPPER 8'h02
`define PATTERN_LOWER 8'h03
`define PATTERN_MAX 8'h03
`define PATTERN_RESET 8'h00
// Output byte pilot positions
`define PILOT_MAIN_BIT 0
`define PILOT_UPPER_BIT 1
`define PILOT_LOWER_BIT 2
`define PILOT_RESET 3'h0
// Input byte sensor positions; upper nibble unused
`define SENSOR_ONE_BIT 0
`define SENSOR_TWO_BIT 1
`define SENSOR_THREE_BIT 2
`define SENSOR_FOUR_BIT 3
`define INPUT_RESET 8'h00
// Acyclic read data after reset
`define RDATA_RESET 8'h00
`endif

// [hw/pilot_safety_decode.v]
// Safety position decoder: pattern code to pilot drives with at most one on
`timescale 1ns/1ps
`include "valve_io_map.vh"
module pilot_safety_decode (
    pattern,
    pilots
);
    input wire [7:0] pattern;
    output reg [2:0] pilots;

    // At most one pilot ever on; unknown codes fall back to all off
    always @* begin
        case (pattern)
            `PATTERN_MAIN: pilots = 3'h1;
            `PATTERN_UPPER: pilots = 3'h2;
            `PATTERN_LOWER: pilots = 3'h4;
            default: pilots = 3'h0;
        endcase
    end
endmodule

// [tb/valve_state_decode.sv]
// Controller model: valve state from sensor bits
`timescale 1ns/1ps
module valve_state_decode (
    input wire [3:0] s,
    output wire [3:0] state
);
    // One-hot lower, upper, open, closed; zero is undefined
    assign state = {s == 4'h1, s == 4'h6, s == 4'h8, s == 4'h5};
endmodule

// [tb/valve_map_sva.sv]
// Port assertions for the valve io mapping
`timescale 1ns/1ps
module valve_map_sva (
    input wire clk, rst_b, out_valid, bus_error, attr_get, attr_set, attr_sel, attr_done, attr_reject,
    input wire in_safety, main_stroke_pilot, upper_lift_pilot, lower_lift_pilot,
    input wire [7:0] sensor_input_byte, pilot_output_byte_in, attr_wdata, attr_rdata
);
    wire [2:0] pil = {lower_lift_pilot, upper_lift_pilot, main_stroke_pilot};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Calm cyclic write; bus error held without safety
    sequence s_take; out_valid && !bus_error ##1 !bus_error; endsequence
    sequence s_hold; bus_error ##1 bus_error && !in_safety ##1 !in_safety; endsequence
    a_input_zero: assert property (sensor_input_byte[7:4] == 4'h0) else $error("input");
    a_pilot_map: assert property (s_take |=> pil == $past(pilot_output_byte_in[2:0], 2)) else $error("map");
    a_hold_last: assert property (s_hold |-> $stable(pil)) else $error("hold");
    a_safe_flag: assert property (in_safety |-> $past(bus_error)) else $error("safe");
    a_mode_zero: assert property (attr_get && !attr_sel |=> attr_rdata[7:1] == 7'h00) else $error("mode");
    a_one_pilot: assert property (in_safety |-> $onehot0(pil)) else $error("one");
    a_done_pulse: assert property (attr_get || attr_set |=> attr_done) else $error("done");
    a_reject_big: assert property (attr_set && attr_sel |=>
        attr_reject == ($past(attr_wdata) > 8'h03)) else $error("reject");
endmodule

// [tb/tb_top.sv]
// Bench for the valve io mapping
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, rst_b = 0, sensor_one = 0, sensor_two = 0, sensor_three = 0, sensor_four = 0;
    logic in_sample = 0, out_valid = 0, bus_error = 0, attr_get = 0, attr_set = 0, attr_sel = 0;
    logic [7:0] pilot_output_byte_in = 0, attr_wdata = 0, sensor_input_byte, attr_rdata;
    logic main_stroke_pilot, upper_lift_pilot, lower_lift_pilot, in_safety, attr_done, attr_reject;
    logic [3:0] state;
    int n_errors = 0, n_tests = 0;
    wire [2:0] pil = {lower_lift_pilot, upper_lift_pilot, main_stroke_pilot};
    valve_fieldbus_io_mapping uut (
        .clk(clk), .rst_b(rst_b), .sensor_one(sensor_one), .sensor_two(sensor_two),
        .sensor_three(sensor_three), .sensor_four(sensor_four), .in_sample(in_sample),
        .sensor_input_byte(sensor_input_byte), .out_valid(out_valid), .pilot_output_byte_in(pilot_output_byte_in),
        .bus_error(bus_error), .attr_get(attr_get), .attr_set(attr_set), .attr_sel(attr_sel),
        .attr_wdata(attr_wdata), .attr_rdata(attr_rdata), .attr_done(attr_done), .attr_reject(attr_reject),
        .main_stroke_pilot(main_stroke_pilot), .upper_lift_pilot(upper_lift_pilot),
        .lower_lift_pilot(lower_lift_pilot), .in_safety(in_safety)
    );
    valve_state_decode plc (.s(sensor_input_byte[3:0]), .state(state));
    initial forever #10 clk = ~clk;
    task chk(input logic [7:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One get or set, held for a single taking edge
    task attr(input logic s, sel, input logic [7:0] d);
        @(posedge clk);
        {attr_set, attr_get, attr_sel, attr_wdata} <= {s, !s, sel, d};
        @(posedge clk);
        {attr_set, attr_get} <= 2'h0;
        #1;
    endtask
    // Sensor capture and pilot command per pattern
    task t_cyc;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {sensor_four, sensor_three, sensor_two, sensor_one} <= 16'h1685 >> 4 * i;
            {in_sample, out_valid, pilot_output_byte_in} <= {2'h3, 8'hF8 | 8'h01 << i % 3};
            @(posedge clk);
            {in_sample, out_valid} <= 2'h0;
            #1 chk(sensor_input_byte, 16'h1685 >> 4 * i & 16'h000F);
            chk(state, 1 << i);
            if (i >= 2) chk(sensor_input_byte[i == 2 ? 2 : 0], 1);
            @(posedge clk);
            #1 chk(pil, 1 << i % 3);
        end
        $display("cyc end");
    endtask
    // Refused code first, so reset pattern must survive
    task t_safe;
        attr(1, 0, 8'hFF);
        attr(0, 0, 8'h00);
        chk(attr_rdata, 8'h01);
        chk(attr_done, 1);
        attr(1, 0, 8'h00);
        for (int p = 4; p >= 0; p--) begin
            attr(1, 1, p);
            chk(attr_reject, p > 3);
            attr(0, 1, 8'h00);
            chk(attr_rdata, p % 4);
            @(posedge clk);
            bus_error <= 1;
            @(posedge clk);
            #1 chk(pil, p % 4 ? 1 << p - 1 : 0);
            chk(in_safety, 1);
            @(posedge clk);
            bus_error <= 0;
        end
        attr(1, 0, 8'h01);
        @(posedge clk);
        {bus_error, out_valid, pilot_output_byte_in} <= 10'h302;
        @(posedge clk);
        out_valid <= 0;
        @(posedge clk);
        #1 chk(pil, 3'h1);
        chk(in_safety, 0);
        $display("safe end");
    endtask
    // Mid-run reset must clear both configuration bytes
    task t_reset;
        attr(1, 1, 8'h02);
        @(posedge clk);
        {bus_error, rst_b} <= 2'h0;
        repeat (2) @(posedge clk);
        rst_b <= 1;
        attr(0, 0, 8'h00);
        chk(attr_rdata, 8'h00);
        attr(0, 1, 8'h00);
        chk(attr_rdata, 8'h00);
        chk(pil, 3'h0);
        $display("reset end");
    endtask
    task test_done;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1;
        t_cyc;
        t_safe;
        t_reset;
        test_done;
    end
endmodule
bind valve_fieldbus_io_mapping valve_map_sva sva (
    .clk(clk), .rst_b(rst_b), .out_valid(out_valid), .bus_error(bus_error), .attr_get(attr_get),
    .attr_set(attr_set), .attr_sel(attr_sel), .attr_done(attr_done), .attr_reject(attr_reject),
    .in_safety(in_safety), .main_stroke_pilot(main_stroke_pilot), .upper_lift_pilot(upper_lift_pilot),
    .lower_lift_pilot(lower_lift_pilot), .sensor_input_byte(sensor_input_byte),
    .pilot_output_byte_in(pilot_output_byte_in), .attr_wdata(attr_wdata), .attr_rdata(attr_rdata)
);
